// ---- hdl/rssa_pkg.sv ----
package rssa_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned MSB_POS  = 7;   // bit that receives old borrow on rotate
  localparam int unsigned LSB_POS  = 0;   // bit that leaves into borrow on rotate
  localparam int unsigned NIB_W    = 4;
  localparam logic [7:0]  ZERO_VAL = 8'h00;
  localparam logic [7:0]  ONE_VAL  = 8'h01;
  localparam logic [7:0]  W_RESET  = 8'h00;
  localparam int unsigned SKIP_CYCLES = 2;  // decrement-and-skip occupies two cycles when it skips

  // operation selector given by the sequencer with each request
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROT_RIGHT_BORROW_TO_W,
    OP_SUB_WITH_BORROW_MEM,
    OP_SUB_WITH_BORROW_IMM,
    OP_SUB_BORROW_TO_MEM,
    OP_DEC_SKIP_NULL,
    OP_DEC_SKIP_NULL_TO_W
  } op_type;

  // status flags kept by the datapath
  typedef struct packed {
    logic signed_wrap_flag;
    logic result_null_flag;
    logic nibble_half_flag;
    logic borrow_out_flag;
    logic signed_borrow_flag;
    logic chained_null_flag;
  } flags_type;

  localparam flags_type FLAGS_RESET = '0;

  // request from the sequencer
  typedef struct packed {
    logic       valid;
    op_type     op;
    logic [7:0] mem_data;
    logic [7:0] imm_data;
  } req_type;

  // memory write-back request
  typedef struct packed {
    logic       write;
    logic [7:0] data;
  } mem_wr_type;

endpackage : rssa_pkg

// ---- hdl/rssa_sub_unit.sv ----
`timescale 1ns/1ns
`default_nettype none

// combinational subtract with borrow and flag derivation
module rssa_sub_unit (
  // operands
  input  wire logic [7:0]          minuend_i,
  input  wire logic [7:0]          subtrahend_i,
  input  wire logic                borrow_in_flag_i,
  input  wire logic                prev_null_flag_i,
  // results
  output logic [7:0]               diff_o,
  output rssa_pkg::flags_type      flags_o
);
  import rssa_pkg::*;

  logic [8:0] wide_diff;
  logic [4:0] low_diff;
  logic [8:0] signed_diff;
  logic       inv_borrow;

  // borrow flag high means no borrow pending, so the inverse is subtracted
  assign inv_borrow = ~borrow_in_flag_i;
  assign wide_diff  = {1'b0, minuend_i} - {1'b0, subtrahend_i} - {8'h00, inv_borrow};
  assign low_diff   = {1'b0, minuend_i[NIB_W-1:0]} - {1'b0, subtrahend_i[NIB_W-1:0]}
                      - {4'h0, inv_borrow};
  assign signed_diff = {minuend_i[MSB_POS], minuend_i} - {subtrahend_i[MSB_POS], subtrahend_i}
                       - {8'h00, inv_borrow};
  assign diff_o = wide_diff[7:0];

  // flag derivation from the true difference
  always_comb begin
    flags_o.borrow_out_flag    = ~wide_diff[8];          // negative clears, else set
    flags_o.nibble_half_flag   = ~low_diff[4];
    flags_o.result_null_flag   = (wide_diff[7:0] == ZERO_VAL);
    flags_o.signed_wrap_flag   = signed_diff[8] ^ signed_diff[7];
    flags_o.signed_borrow_flag = signed_diff[8];        // sign of the unclipped result
    // chained zero keeps an earlier non-zero byte of a multibyte subtract
    flags_o.chained_null_flag  = (wide_diff[7:0] == ZERO_VAL) & prev_null_flag_i;
  end

endmodule // rssa_sub_unit
`default_nettype wire

// ---- hdl/rotate_subtract_skip_alu.sv ----
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// (RULE1) rotate right: old borrow into bit 7, operand bit 0 into borrow
// (RULE2) rotate writes only working register; memory and other flags untouched
// (RULE3) memory subtract: working minus byte minus inverted borrow into working
// (RULE4) immediate subtract: working minus immediate minus inverted borrow into working
// (RULE5) subtract to memory: same difference written back to memory
// (RULE6) borrow flag cleared on negative difference, set on zero or positive
// (RULE7) every subtract variant updates all six status flags
// (RULE8) decrement memory byte, write back, skip next when result zero
// (RULE9) decrement into working register, memory unchanged, skip when zero
// (RULE10) a taken skip inserts a dummy cycle, two cycles in total
// (RULE11) non-zero decrement result continues with next instruction
// (RULE12) decrement-and-skip leaves every status flag unchanged
module rotate_subtract_skip_alu (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // request from the sequencer
  input  wire rssa_pkg::req_type   req_i,
  // architectural state
  output logic [7:0]               working_register_o,
  output rssa_pkg::flags_type      flags_o,
  // data memory write-back
  output rssa_pkg::mem_wr_type     mem_wr_o,
  // sequencer handshake
  output logic                     skip_next_o,
  output logic                     dummy_cycle_o,
  output logic                     busy_o
);
  import rssa_pkg::*;

  typedef enum logic [0:0] {
    ST_EXEC,
    ST_DUMMY
  } state_type;

  state_type  state;
  state_type  next_state;
  logic [7:0] working_register;
  logic [7:0] next_working_register;
  flags_type  flags;
  flags_type  next_flags;
  mem_wr_type mem_wr;
  mem_wr_type next_mem_wr;
  logic       skip_next;
  logic       next_skip_next;
  logic       dummy_cycle;
  logic       next_dummy_cycle;

  // sequencer handshake helpers
  logic       busy;
  logic       next_busy;
  logic       taken;      // valid request outside the dummy slot; accepted at an enabled edge
  logic       skip_hit;   // taken decrement with a zero result

  logic [7:0] sub_operand;
  logic [7:0] sub_diff;
  flags_type  sub_flags;
  logic [7:0] dec_val;

  ////////////////////////////////////////////////////////////////////////////////
  // decrement of a byte, shared by both skip forms
  function automatic logic [7:0] dec_byte(input logic [7:0] value);
    dec_byte = value - ONE_VAL;
  endfunction

  // rotate right through the borrow flag
  function automatic logic [7:0] rot_right(input logic [7:0] value, input logic bin);
    rot_right = {bin, value[MSB_POS:LSB_POS+1]};
  endfunction

  // the two decrement-and-skip forms share one skip decision; keeping the
  // decode in one place stops the datapath and sequencer from drifting apart
  function automatic logic is_dec_skip(input op_type op);
    is_dec_skip = (op == OP_DEC_SKIP_NULL) || (op == OP_DEC_SKIP_NULL_TO_W);
  endfunction

  // immediate and memory forms share one subtractor
  assign sub_operand = (req_i.op == OP_SUB_WITH_BORROW_IMM) ? req_i.imm_data : req_i.mem_data;
  assign dec_val     = dec_byte(req_i.mem_data);

  rssa_sub_unit u_sub (
    .minuend_i        (working_register),
    .subtrahend_i     (sub_operand),
    .borrow_in_flag_i (flags.borrow_out_flag),
    .prev_null_flag_i (flags.chained_null_flag),
    .diff_o           (sub_diff),
    .flags_o          (sub_flags)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // a request is taken only outside the dummy slot; there it is refused
  // silently, since the sequencer already discards that instruction itself
  assign taken    = req_i.valid && (state == ST_EXEC);
  assign skip_hit = taken && is_dec_skip(req_i.op) && (dec_val == ZERO_VAL);

  ////////////////////////////////////////////////////////////////////////////////
  // next values of the working register, flags and memory write-back;
  // a frozen cycle is held at the registers, so nothing here looks at ce_i
  always_comb begin
    next_working_register = working_register;
    next_flags            = flags;
    next_mem_wr           = '0;   // write-back is a pulse of one enabled cycle
    if (taken) begin
      case (req_i.op)
        OP_ROT_RIGHT_BORROW_TO_W: begin
          // (RULE1) rotate through borrow
          next_working_register      = rot_right(req_i.mem_data, flags.borrow_out_flag);
          next_flags.borrow_out_flag = req_i.mem_data[LSB_POS];
          // (RULE2) no memory write here
          next_mem_wr.write          = 1'b0;
        end
        OP_SUB_WITH_BORROW_MEM, OP_SUB_WITH_BORROW_IMM: begin
          // (RULE3) (RULE4) difference to working register
          next_working_register = sub_diff;
          // (RULE6) (RULE7) all six flags from the result
          next_flags            = sub_flags;
        end
        OP_SUB_BORROW_TO_MEM: begin
          // (RULE5) difference back to memory
          next_mem_wr.write = 1'b1;
          next_mem_wr.data  = sub_diff;
          // (RULE7) flags follow here too
          next_flags        = sub_flags;
        end
        OP_DEC_SKIP_NULL: begin
          // (RULE8) decrement back to memory; flags untouched (RULE12)
          next_mem_wr.write = 1'b1;
          next_mem_wr.data  = dec_val;
        end
        OP_DEC_SKIP_NULL_TO_W: begin
          // (RULE9) decrement into working register; memory left alone
          next_working_register = dec_val;
        end
        default: begin
          // idle and unused codes leave the datapath as it is
          next_working_register = working_register;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next values of the sequencer handshake; the skip pulse, the dummy
  // marker and busy rise together and fall after one enabled cycle
  always_comb begin
    next_state       = state;
    next_skip_next   = 1'b0;
    next_dummy_cycle = 1'b0;
    next_busy        = 1'b0;
    case (state)
      ST_DUMMY: begin
        // (RULE10) dummy slot ends
        // a request arriving now belongs to the discarded instruction
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        // (RULE11) skip only on zero, else run on
        if (skip_hit) begin
          // (RULE10) discard next, insert dummy
          next_skip_next   = 1'b1;
          next_dummy_cycle = 1'b1;
          next_busy        = 1'b1;
          next_state       = ST_DUMMY;
        end
      end
      default: begin
        // an illegal state code falls back to normal execution
        next_state = ST_EXEC;
      end
    endcase
  end

  // datapath registers; clock enable freezes everything
  // reset beats the enable so a frozen core still clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      working_register <= W_RESET;
      flags            <= FLAGS_RESET;
      mem_wr           <= '0;
    end else if (ce_i) begin
      working_register <= next_working_register;
      flags            <= next_flags;
      mem_wr           <= next_mem_wr;
    end
  end

  // sequencer registers; busy has its own flop so the output needs no decode,
  // at the cost of one flop that always mirrors the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= ST_EXEC;
      skip_next   <= 1'b0;
      dummy_cycle <= 1'b0;
      busy        <= 1'b0;
    end else if (ce_i) begin
      state       <= next_state;
      skip_next   <= next_skip_next;
      dummy_cycle <= next_dummy_cycle;
      busy        <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops, so the sequencer sees clean
  // levels with a full cycle of settling
  always_comb begin
    working_register_o = working_register;
    flags_o            = flags;
    mem_wr_o           = mem_wr;
    skip_next_o        = skip_next;
    dummy_cycle_o      = dummy_cycle;
    busy_o             = busy;
  end

endmodule // rotate_subtract_skip_alu
`default_nettype wire

// ---- verification/rssa_checker_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////
module rssa_checker (
  // clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 ce_i,
  // request and results
  input wire rssa_pkg::req_type    req_i,
  input wire logic [7:0]           working_register_o,
  input wire rssa_pkg::flags_type  flags_o,
  input wire rssa_pkg::mem_wr_type mem_wr_o,
  input wire logic                 skip_next_o,
  input wire logic                 dummy_cycle_o,
  input wire logic                 busy_o
);
  import rssa_pkg::*;
  logic       tk, nb, sub, dec;
  logic [8:0] dm, di, ds;
  // a request counts only when enabled and outside the dummy slot
  assign tk  = ce_i && req_i.valid && !busy_o;
  assign nb  = ~flags_o.borrow_out_flag;
  assign sub = tk && req_i.op inside {OP_SUB_WITH_BORROW_MEM, OP_SUB_WITH_BORROW_IMM,
                                      OP_SUB_BORROW_TO_MEM};
  assign dec = tk && req_i.op inside {OP_DEC_SKIP_NULL, OP_DEC_SKIP_NULL_TO_W};
  // nine bits so the borrow out of the byte stays visible
  assign dm  = {1'b0, working_register_o} - {1'b0, req_i.mem_data} - {8'h00, nb};
  assign di  = {1'b0, working_register_o} - {1'b0, req_i.imm_data} - {8'h00, nb};
  assign ds  = (req_i.op == OP_SUB_WITH_BORROW_IMM) ? di : dm;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // every result is due one cycle after the taking edge
  AST_ROT: assert property (tk && req_i.op == OP_ROT_RIGHT_BORROW_TO_W |=>
    working_register_o == {$past(flags_o.borrow_out_flag), $past(req_i.mem_data[7:1])}
    && flags_o.borrow_out_flag == $past(req_i.mem_data[0])) else $error("rotate wrong");
  AST_ROT_ONLY: assert property (tk && req_i.op == OP_ROT_RIGHT_BORROW_TO_W |=>
    !mem_wr_o.write && $stable({flags_o.signed_wrap_flag, flags_o.result_null_flag,
    flags_o.nibble_half_flag, flags_o.signed_borrow_flag, flags_o.chained_null_flag}))
    else $error("rotate side effect");
  AST_SUB_W: assert property (sub && req_i.op != OP_SUB_BORROW_TO_MEM |=>
    working_register_o == $past(ds[7:0])) else $error("subtract result wrong");
  AST_SUB_MEM: assert property (tk && req_i.op == OP_SUB_BORROW_TO_MEM |=>
    mem_wr_o.write && mem_wr_o.data == $past(dm[7:0]) && $stable(working_register_o))
    else $error("subtract to memory wrong");
  AST_SUB_FLAGS: assert property (sub |=> flags_o.borrow_out_flag == !$past(ds[8]) &&
    flags_o.result_null_flag == ($past(ds[7:0]) == 8'h00) &&
    flags_o.chained_null_flag == ($past(ds[7:0]) == 8'h00 && $past(flags_o.chained_null_flag)))
    else $error("subtract flags wrong");
  AST_DEC_MEM: assert property (tk && req_i.op == OP_DEC_SKIP_NULL |=>
    mem_wr_o.write && mem_wr_o.data == $past(req_i.mem_data) - 8'h01) else $error("dec wrong");
  AST_DEC_W: assert property (tk && req_i.op == OP_DEC_SKIP_NULL_TO_W |=>
    !mem_wr_o.write && working_register_o == $past(req_i.mem_data) - 8'h01)
    else $error("dec to working wrong");
  AST_SKIP: assert property (dec && req_i.mem_data == 8'h01 |=>
    skip_next_o && dummy_cycle_o && busy_o) else $error("skip missing");
  AST_SKIP_END: assert property (busy_o && ce_i |=>
    !busy_o && !skip_next_o && !dummy_cycle_o) else $error("dummy slot too long");
  AST_NO_SKIP: assert property (dec && req_i.mem_data != 8'h01 |=>
    !skip_next_o && !busy_o) else $error("unexpected skip");
  AST_DEC_FLAGS: assert property (dec |=> $stable(flags_o)) else $error("dec changed flags");
  // main scenarios reached
  COV_SKIP: cover property (skip_next_o && busy_o);
  COV_NEG: cover property (sub && ds[8]);
  COV_REFUSED: cover property (busy_o && req_i.valid);
endmodule // rssa_checker
bind rotate_subtract_skip_alu rssa_checker i_chk (.clk_i, .rst_i, .ce_i, .req_i,
  .working_register_o, .flags_o, .mem_wr_o, .skip_next_o, .dummy_cycle_o, .busy_o);
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////
module testbench;
  import rssa_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b0, c, sk = 1'b0;
  req_type     req_i = '0, r;
  logic [7:0]  working_register_o, w = '0;
  flags_type   flags_o, f = '0;
  mem_wr_type  mem_wr_o, mw = '0;
  logic        skip_next_o, dummy_cycle_o, busy_o;
  logic [25:0] e, got, exp_q[$];
  int          fail_count = 0, samples_checked = 0;
  assign got = {working_register_o, flags_o, mem_wr_o, skip_next_o, dummy_cycle_o, busy_o};
  rotate_subtract_skip_alu i_dut (.clk_i, .rst_i, .ce_i, .req_i, .working_register_o,
    .flags_o, .mem_wr_o, .skip_next_o, .dummy_cycle_o, .busy_o);
  always #20 clk_i = ~clk_i;
  // reference: one edge of the datapath; a frozen edge repeats the last state
  task automatic step();
    logic [7:0] b;
    logic [8:0] d;
    logic [4:0] lo;
    logic       sw;
    b = (r.op == OP_SUB_WITH_BORROW_IMM) ? r.imm_data : r.mem_data;
    d = {1'b0, w} - {1'b0, b} - {8'h00, ~f.borrow_out_flag};
    lo = {1'b0, w[3:0]} - {1'b0, b[3:0]} - {4'h0, ~f.borrow_out_flag};
    sw = (w[7] != b[7]) && (d[7] != w[7]);
    if (c) begin
      mw = '0;
      if (r.valid && !sk) begin
        case (r.op)
          OP_NONE: ;
          OP_ROT_RIGHT_BORROW_TO_W: {w, f.borrow_out_flag} = {f.borrow_out_flag, r.mem_data};
          OP_DEC_SKIP_NULL: mw = {1'b1, r.mem_data - 8'h01};
          OP_DEC_SKIP_NULL_TO_W: w = r.mem_data - 8'h01;
          default: begin
            f = '{sw, d[7:0] == 8'h00, !lo[4], !d[8], d[7] ^ sw,
                  d[7:0] == 8'h00 && f.chained_null_flag};
            if (r.op == OP_SUB_BORROW_TO_MEM) mw = {1'b1, d[7:0]};
            else w = d[7:0];
          end
        endcase
      end
      // a refused request in the dummy slot can never start a new skip
      sk = !sk && r.valid && r.op inside {OP_DEC_SKIP_NULL, OP_DEC_SKIP_NULL_TO_W}
           && r.mem_data == 8'h01;
    end
    exp_q.push_back({w, f, mw, sk, sk, sk});
  endtask
  // random request; low memory bytes are favoured so skips and wraps occur
  task automatic pick();
    r.valid = $urandom_range(0, 3) != 0;
    r.op = op_type'($urandom_range(0, 6));
    r.mem_data = ($urandom_range(0, 2) == 0) ? 8'($urandom_range(0, 1)) : 8'($urandom);
    r.imm_data = 8'($urandom);
    c = $urandom_range(0, 7) != 0;
    req_i <= r;
    ce_i <= c;
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // driver: reset for 16 edges, then one random request per edge
  initial begin
    void'($urandom(60));
    repeat (15) @(posedge clk_i);
    for (int i = 0; i < 800; i++) begin
      @(posedge clk_i);
      if (i > 0) step();
      rst_i <= 1'b0;
      pick();
    end
    // the last request is noted too, so every random request is checked
    @(posedge clk_i);
    step();
    repeat (2) @(posedge clk_i);
    give_verdict();
  end
  // monitor: outputs settle, then the oldest note is compared
  initial forever begin
    @(posedge clk_i);
    #1;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      samples_checked++;
      if (got !== e) begin
        fail_count++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
      end
    end
  end
  // watchdog well beyond the roughly 820 cycles the run needs
  initial begin
    repeat (1200) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
